// ### rtl/pll_cfg_pkg.sv
// constants for the clock-mode configuration block
// assumes an APB slave with 32-bit data, one word per register
package pll_cfg_pkg;
  // register indices; printed offsets are not all multiples of four
  localparam logic [8:0]  IDX_PLL_CTRL   = 9'h010;
  localparam logic [8:0]  IDX_VCO_DIV    = 9'h1E0;
  localparam logic [8:0]  IDX_DIV_ROUTE  = 9'h1E1;
  localparam logic [8:0]  IDX_NVM_CTRL   = 9'h1F0;
  localparam logic [8:0]  IDX_STATUS     = 9'h1F1;
  localparam int          PWR_LSB        = 0;
  localparam int          POL_BIT        = 7;
  localparam int          BYP_BIT        = 0;
  localparam int          NVM_SAVE_BIT   = 0;
  localparam int          NVM_LOAD_BIT   = 1;
  localparam logic [1:0]  PWR_ON         = 2'h0;
  localparam logic [1:0]  PWR_OFF        = 2'h1;
  localparam logic [1:0]  PWR_RST        = 2'h1;
  localparam logic [2:0]  DIVSEL_RST     = 3'h0;
  localparam logic        BYP_RST        = 1'h0;
  localparam logic        POL_RST        = 1'h0;
  localparam int          CFG_W          = 7;
  localparam logic [3:0]  DIV_RATIO_MIN  = 4'h1;
  localparam logic [3:0]  DIV_RATIO_MAX  = 4'h6;
  localparam logic [3:0]  DIV_RATIO_RST  = 4'h2;
endpackage

// ### rtl/cfg_store_if.sv
// carrier between the config block and its nonvolatile store
// assumes both ends share clk
`timescale 1ns/1ps
interface cfg_store_if;
  logic                           saveReq;
  logic                           loadReq;
  logic [pll_cfg_pkg::CFG_W-1:0]  wrData;
  logic [pll_cfg_pkg::CFG_W-1:0]  rdData;
  logic                           rdValid;
  logic                           valid;
  modport ctrl  (output saveReq, output loadReq, output wrData,
                 input rdData, input rdValid, input valid);
  modport store (input saveReq, input loadReq, input wrData,
                 output rdData, output rdValid, output valid);
endinterface

// ### rtl/cfg_nv_store.sv
// nonvolatile configuration image; survives srst, not modelled across power loss
// assumes one save or load request per cycle at most
`timescale 1ns/1ps
module cfg_nv_store
(
  input  wire logic  clk,
  input  wire logic  ce,
  cfg_store_if.store st
);
  logic [pll_cfg_pkg::CFG_W-1:0] image_reg;
  // an empty store at power-up, set by declaration so only the clocked process writes them
  logic                          valid_reg   = 1'b0;
  logic                          rdValid_reg = 1'b0;

  // no reset on purpose: the stored image must outlive a chip reset
  always_ff @(posedge clk)
  begin
    if (ce && st.saveReq)
    begin
      image_reg <= st.wrData;
      valid_reg <= 1'b1;
    end
    if (ce)
      rdValid_reg <= st.loadReq && valid_reg;
  end

  assign st.rdData  = image_reg;
  assign st.rdValid = rdValid_reg;
  assign st.valid   = valid_reg;
endmodule

// ### rtl/pll_mode_clock_routing_config.sv
// clock mode control: PLL power, detector polarity, VCO divider routing
// assumes an APB master on clk; power-up load from the store after srst
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module pll_mode_clock_routing_config
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             pllPowerDown,
  output logic             pllOn,
  output logic             polarityNeg,
  output logic             divBypass,
  output logic [3:0]       divRatio,
  output logic             prescalerFromVco
);
  cfg_store_if st ();

  cfg_nv_store u_store
  (
    .clk (clk),
    .ce  (ce),
    .st  (st)
  );

  logic [1:0] pwr_reg;
  logic [1:0] pwr_next;
  logic       pol_reg;
  logic       pol_next;
  logic [2:0] divSel_reg;
  logic [2:0] divSel_next;
  logic       byp_reg;
  logic       byp_next;
  logic       bootPend_reg;
  logic       loadWait_reg;
  logic [3:0] ratio_reg;
  logic [31:0] rdata_reg;

  logic [8:0] idx;
  logic       access;
  logic       wrAcc;
  logic       rdAcc;
  logic       hitCtrl;
  logic       hitDiv;
  logic       hitRoute;
  logic       hitNvm;
  logic       hitStat;
  logic       mapped;
  logic       doSave;
  logic       doLoad;
  logic [pll_cfg_pkg::CFG_W-1:0] cfgNow;

  assign idx      = paddr[10:2];
  assign access   = psel && penable && ce;
  assign wrAcc    = access && pwrite;
  assign rdAcc    = access && !pwrite;
  assign hitCtrl  = (idx == pll_cfg_pkg::IDX_PLL_CTRL) && (paddr[1:0] == 2'h0) && !paddr[11];
  assign hitDiv   = (idx == pll_cfg_pkg::IDX_VCO_DIV) && (paddr[1:0] == 2'h0) && !paddr[11];
  assign hitRoute = (idx == pll_cfg_pkg::IDX_DIV_ROUTE) && (paddr[1:0] == 2'h0) && !paddr[11];
  assign hitNvm   = (idx == pll_cfg_pkg::IDX_NVM_CTRL) && (paddr[1:0] == 2'h0) && !paddr[11];
  assign hitStat  = (idx == pll_cfg_pkg::IDX_STATUS) && (paddr[1:0] == 2'h0) && !paddr[11];
  assign mapped   = hitCtrl || hitDiv || hitRoute || hitNvm || hitStat;
  assign doSave   = wrAcc && hitNvm && pwdata[pll_cfg_pkg::NVM_SAVE_BIT];
  assign doLoad   = (wrAcc && hitNvm && pwdata[pll_cfg_pkg::NVM_LOAD_BIT]) || bootPend_reg;
  assign cfgNow   = {byp_reg, divSel_reg, pol_reg, pwr_reg};

  assign st.saveReq = doSave;
  assign st.wrData  = cfgNow;
  assign st.loadReq = ce && doLoad && st.valid;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = rdata_reg;

  // register next values; a restore from the store overrides software writes
  always_comb
  begin
    pwr_next    = pwr_reg;
    pol_next    = pol_reg;
    divSel_next = divSel_reg;
    byp_next    = byp_reg;
    if (st.rdValid)
    begin
      pwr_next    = st.rdData[1:0];
      pol_next    = st.rdData[2];
      divSel_next = st.rdData[5:3];
      byp_next    = st.rdData[6];
    end
    else if (wrAcc)
    begin
      if (hitCtrl)
      begin
        pwr_next = pwdata[pll_cfg_pkg::PWR_LSB +: 2];
        pol_next = pwdata[pll_cfg_pkg::POL_BIT];
      end
      if (hitDiv)
        divSel_next = pwdata[2:0];
      if (hitRoute)
        byp_next = pwdata[pll_cfg_pkg::BYP_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pwr_reg      <= pll_cfg_pkg::PWR_RST;
      pol_reg      <= pll_cfg_pkg::POL_RST;
      divSel_reg   <= pll_cfg_pkg::DIVSEL_RST;
      byp_reg      <= pll_cfg_pkg::BYP_RST;
      bootPend_reg <= 1'b1;
      loadWait_reg <= 1'b0;
    end
    else if (ce)
    begin
      pwr_reg      <= pwr_next;
      pol_reg      <= pol_next;
      divSel_reg   <= divSel_next;
      byp_reg      <= byp_next;
      bootPend_reg <= 1'b0;
      loadWait_reg <= st.loadReq;
    end
  end

  // select codes 000..101 give ratios 2,3,4,5,6,1; codes above hold the top ratio
  logic [3:0] ratioDec;
  assign ratioDec = (divSel_reg == 3'h5) ? pll_cfg_pkg::DIV_RATIO_MIN :
                    (divSel_reg > 3'h5)  ? pll_cfg_pkg::DIV_RATIO_MAX :
                    4'(divSel_reg) + pll_cfg_pkg::DIV_RATIO_RST;

  always_ff @(posedge clk)
  begin
    if (srst)
      ratio_reg <= pll_cfg_pkg::DIV_RATIO_RST;
    else if (ce)
      ratio_reg <= ratioDec;
  end

  logic [31:0] rdMux;
  assign rdMux = hitCtrl  ? {24'h0, pol_reg, 5'h0, pwr_reg} :
                 hitDiv   ? {29'h0, divSel_reg} :
                 hitRoute ? {31'h0, byp_reg} :
                 hitStat  ? {24'h0, st.valid, loadWait_reg, pllOn, pllPowerDown,
                             ratio_reg} :
                 32'h0;

  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_reg <= 32'h0;
    else if (ce && psel && !penable && !pwrite)
      rdata_reg <= rdMux;
  end

  // pins that steer the analog section; 10b and 11b leave the PLL powered down
  assign pllPowerDown     = (pwr_reg != pll_cfg_pkg::PWR_ON);
  assign pllOn            = (pwr_reg == pll_cfg_pkg::PWR_ON);
  assign polarityNeg      = pol_reg;
  assign divBypass        = byp_reg;
  assign divRatio         = ratio_reg;
  // the prescaler takes the VCO only while the PLL is on and the divider is not bypassed
  assign prescalerFromVco = pllOn && !byp_reg;
  // bypass above 1600 MHz is the caller's duty; nothing here can see the frequency

  property p_pwrdown;
    @(posedge clk) disable iff (srst)
    (pwr_reg == pll_cfg_pkg::PWR_OFF) |-> pllPowerDown && !pllOn;
  endproperty
  a_pwrdown: assert property (p_pwrdown) else $error("pll not down for 01b");

  property p_pwron;
    @(posedge clk) disable iff (srst)
    (ce && wrAcc && hitCtrl && pwdata[1:0] == 2'h0 && !st.rdValid) |=> pllOn;
  endproperty
  a_pwron: assert property (p_pwron) else $error("pll not on after 00b write");

  property p_bypass;
    @(posedge clk) disable iff (srst)
    (ce && wrAcc && hitRoute && !st.rdValid) |=> (divBypass == $past(pwdata[0]));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not taken");

  property p_ratio;
    @(posedge clk) disable iff (srst)
    divRatio >= 4'h1 && divRatio <= 4'h6;
  endproperty
  a_ratio: assert property (p_ratio) else $error("divide ratio out of range");

  property p_reset;
    @(posedge clk) srst |=> pllPowerDown && !divBypass && divRatio == 4'h2;
  endproperty
  a_reset: assert property (p_reset) else $error("reset defaults wrong");

  property p_pol;
    @(posedge clk) disable iff (srst)
    (ce && wrAcc && hitCtrl && !st.rdValid) |=> (polarityNeg == $past(pwdata[7]));
  endproperty
  a_pol: assert property (p_pol) else $error("polarity not taken");

  property p_prescale;
    @(posedge clk) disable iff (srst)
    prescalerFromVco == (pwr_reg == pll_cfg_pkg::PWR_ON && !byp_reg);
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler feed wrong");

  property p_restore;
    @(posedge clk) disable iff (srst)
    (ce && st.loadReq) |=> ##1 (!$past(ce) || {divBypass, divSel_reg, polarityNeg, pwr_reg}
                                               == $past(st.rdData, 2));
  endproperty
  a_restore: assert property (p_restore) else $error("restore not applied");

  // checker table kept apart from the decode above, so a slip in either one shows up
  localparam logic [3:0] RATIO_TAB [8] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h1, 4'h6, 4'h6};
  logic [3:0] ratioChk;
  logic       setupRd;
  assign ratioChk = RATIO_TAB[divSel_reg];
  assign setupRd  = ce && psel && !penable && !pwrite;

  property p_pwroff;
    @(posedge clk) disable iff (srst)
    (wrAcc && hitCtrl && pwdata[1:0] == pll_cfg_pkg::PWR_OFF && !st.rdValid)
      |=> pllPowerDown && !pllOn && !prescalerFromVco;
  endproperty
  a_pwroff: assert property (p_pwroff) else $error("pll not down after 01b write");

  property p_divsel;
    @(posedge clk) disable iff (srst)
    (wrAcc && hitDiv && !st.rdValid) |=> (divSel_reg == $past(pwdata[2:0]));
  endproperty
  a_divsel: assert property (p_divsel) else $error("divider select not taken");

  property p_ratiomap;
    @(posedge clk) disable iff (srst)
    (ce && !srst) |=> (divRatio == $past(ratioChk));
  endproperty
  a_ratiomap: assert property (p_ratiomap) else $error("divide ratio decode wrong");

  property p_polreset;
    @(posedge clk) srst |=> !polarityNeg;
  endproperty
  a_polreset: assert property (p_polreset) else $error("polarity reset wrong");

  // srst is not gated by ce, so a frozen cycle with reset sampled is left out
  property p_freeze;
    @(posedge clk) disable iff (srst)
    (!ce && !srst) |=> ($stable(cfgNow) && $stable(divRatio) && $stable(st.valid));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while ce low");

  property p_cfghold;
    @(posedge clk) disable iff (srst)
    (!srst && !wrAcc && !st.rdValid) |=> $stable(cfgNow);
  endproperty
  a_cfghold: assert property (p_cfghold) else $error("config moved with no cause");

  property p_unmapped;
    @(posedge clk) disable iff (srst)
    (wrAcc && !mapped && !st.rdValid) |=> $stable(cfgNow);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write took effect");

  property p_rddata;
    @(posedge clk) disable iff (srst)
    (rdAcc && $past(setupRd)) |-> (prdata == $past(rdMux));
  endproperty
  a_rddata: assert property (p_rddata) else $error("read data not from setup cycle");

  property p_save;
    @(posedge clk) disable iff (srst)
    doSave |=> (st.valid && st.rdData == $past(cfgNow));
  endproperty
  a_save: assert property (p_save) else $error("save not stored");

  // restore wins over a software write that lands in the same cycle
  property p_restwin;
    @(posedge clk) disable iff (srst)
    (ce && !srst && st.rdValid) |=> (cfgNow == $past(st.rdData));
  endproperty
  a_restwin: assert property (p_restwin) else $error("restore lost to a write");

  property p_loadwait;
    @(posedge clk) disable iff (srst)
    (ce && !srst && st.loadReq) |=> loadWait_reg;
  endproperty
  a_loadwait: assert property (p_loadwait) else $error("load flag not raised");

  property p_nvload;
    @(posedge clk) disable iff (srst)
    (wrAcc && hitNvm && !st.valid) |=> !st.rdValid;
  endproperty
  a_nvload: assert property (p_nvload) else $error("load from empty store");

  // a one-edge reset reaches the store a cycle later, hence the two-cycle window
  property p_boot;
    @(posedge clk) disable iff (srst)
    ($fell(srst) && ce && $past(ce) && st.valid) |-> ##[1:2] (cfgNow == st.rdData);
  endproperty
  a_boot: assert property (p_boot) else $error("saved config not loaded at start");
endmodule

// ### dv/vco_src_model.sv
// far-side model: external clock source feeding the routing
// assumes the source frequency stays fixed for the whole run
`timescale 1ns/1ps
module vco_src_model
#(
  parameter int SRC_MHZ = 1200
)
(
  input  wire logic clk,
  input  wire logic divBypass,
  output logic      overLimit
);
  // a fast source routed around the divider would overrun the channel dividers
  always_ff @(posedge clk)
  begin
    overLimit <= divBypass && (SRC_MHZ > 1600);
  end
endmodule

// ### dv/testbench.sv
// self-checking bench for the clock mode configuration block
// assumes an APB slave on clk and a store image that survives srst
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        srst;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        pdn;
  logic        on;
  logic        neg;
  logic        byp;
  logic [3:0]  ratio;
  logic        pre;
  logic        overLimit;
  logic [31:0] rd;
  logic        err;
  int          errTotal;
  int          checked;
  localparam logic [11:0] A_PLL = {1'h0, pll_cfg_pkg::IDX_PLL_CTRL, 2'h0};
  localparam logic [11:0] A_DIV = {1'h0, pll_cfg_pkg::IDX_VCO_DIV, 2'h0};
  localparam logic [11:0] A_BYP = {1'h0, pll_cfg_pkg::IDX_DIV_ROUTE, 2'h0};
  localparam logic [11:0] A_NVM = {1'h0, pll_cfg_pkg::IDX_NVM_CTRL, 2'h0};
  localparam logic [11:0] A_STAT = {1'h0, pll_cfg_pkg::IDX_STATUS, 2'h0};

  pll_mode_clock_routing_config pll_mode_clock_routing_config_i
  (
    .clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pllPowerDown(pdn), .pllOn(on),
    .polarityNeg(neg), .divBypass(byp), .divRatio(ratio), .prescalerFromVco(pre)
  );
  vco_src_model vco_src_model_i
  (
    .clk(clk), .divBypass(byp), .overLimit(overLimit)
  );

  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", errTotal, checked);
    if (errTotal == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic isWr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= isWr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1)
    begin
      errTotal++;
      $display("[ERR] pready expected 1 seen %b", pready);
      close_out();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  // outputs follow a write after at most three edges
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic do_reset;
    @(posedge clk);
    srst <= 1'h1;
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic t_defaults;
    chk("pdn", 32'h1, pdn);
    chk("ratio", 32'h2, ratio);
    chk("byp", 32'h0, byp);
    chk("neg", 32'h0, neg);
    apb(1'h0, A_PLL, 32'h0);
    chk("pllReg", 32'h1, rd);
    apb(1'h0, A_DIV, 32'h0);
    chk("divReg", 32'h0, rd);
    apb(1'h0, A_STAT, 32'h0);
    chk("status", 32'h12, rd);
  endtask

  task automatic t_power;
    wr(A_PLL, 32'h0);
    chk("on", 32'h1, on);
    chk("pre", 32'h1, pre);
    @(posedge clk);
    ce <= 1'h0;
    wr(A_PLL, 32'h1);
    chk("frozen", 32'h1, on);
    @(posedge clk);
    ce <= 1'h1;
    wr(A_PLL, 32'h1);
    chk("pdn", 32'h1, pdn);
    chk("pre", 32'h0, pre);
  endtask

  task automatic t_polarity;
    wr(A_PLL, 32'h80);
    chk("neg", 32'h1, neg);
    apb(1'h0, A_PLL, 32'h0);
    chk("pllReg", 32'h80, rd);
    wr(A_PLL, 32'h0);
    chk("neg", 32'h0, neg);
  endtask

  task automatic t_divider;
    logic [3:0] exp [8] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h1, 4'h6, 4'h6};
    for (int i = 0; i < 8; i++)
    begin
      wr(A_DIV, 32'(i));
      chk("ratio", 32'(exp[i]), ratio);
    end
  endtask

  task automatic t_bypass;
    wr(A_BYP, 32'h1);
    chk("byp", 32'h1, byp);
    chk("pre", 32'h0, pre);
    wr(A_BYP, 32'h0);
    chk("byp", 32'h0, byp);
    apb(1'h0, 12'h100, 32'h0);
    chk("slverr", 32'h1, err);
    chk("rdBad", 32'h0, rd);
    wr(12'h100, 32'hFFFFFFFF);
    chk("slverrWr", 32'h1, err);
    chk("byp", 32'h0, byp);
    chk("neg", 32'h0, neg);
  endtask

  task automatic t_restore;
    wr(A_PLL, 32'h80);
    wr(A_DIV, 32'h3);
    wr(A_BYP, 32'h1);
    wr(A_NVM, 32'h1);
    do_reset();
    chk("neg", 32'h1, neg);
    chk("on", 32'h1, on);
    chk("ratio", 32'h5, ratio);
    chk("byp", 32'h1, byp);
    wr(A_PLL, 32'h1);
    chk("pdn", 32'h1, pdn);
    wr(A_NVM, 32'h2);
    chk("neg", 32'h1, neg);
    chk("on", 32'h1, on);
    apb(1'h0, A_STAT, 32'h0);
    chk("status", 32'hA5, rd);
  endtask

  initial
  begin
    srst = 1'h1;
    ce = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    errTotal = 0;
    checked = 0;
    do_reset();
    t_defaults();
    t_power();
    t_polarity();
    t_divider();
    t_bypass();
    t_restore();
    chk("overLimit", 32'h0, overLimit);
    close_out();
  end
endmodule
